// ### rtl/srcfc_pkg.sv
// Package with register map, field layout, constants and carrier types of the switch traffic control block.
package srcfc_pkg;
  localparam int NUM_PRI = 8;
  localparam int NUM_SETS = 3;
  localparam int NUM_SHAPERS = NUM_PRI * NUM_SETS;
  localparam int NUM_LANES = 6;
  localparam int NUM_ETH = 2;
  localparam int NUM_DEST = 3;
  // Register byte offsets.
  localparam logic [7:0] ADDR_SWITCH_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HOST_PRI = 8'h04;
  localparam logic [7:0] ADDR_PORT_PRI = 8'h08;
  localparam logic [7:0] ADDR_MAC_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_THRESH = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [2:0] PAGE_HOST_SHAPE = 3'h2;
  localparam logic [2:0] PAGE_PORT_SHAPE = 3'h3;
  // Field positions.
  localparam int CTRL_HOST_CRC_BIT = 0;
  localparam int CTRL_HOST_FLOW_BIT = 1;
  localparam int MAC_CRC_BIT = 0;
  localparam int MAC_FLOW_BIT = 1;
  localparam int MAC_PORT_STRIDE = 8;
  localparam int P1_MIN_LSB = 8;
  localparam int P2_MIN_LSB = 16;
  localparam int PORT_RLIM_STRIDE = 8;
  localparam int SHAPE_IDLE_LSB = 16;
  localparam int STAT_TRIG_LSB = 24;
  localparam int STAT_RETRY_LSB = 26;
  // Reset values.
  localparam logic HOST_FLOW_RESET = 1'b1;
  localparam logic [15:0] THRESH_RESET = 16'h0100;
  // Rate accounting: the switch bus moves 256 bits per clock.
  localparam int BUS_BITS_PER_CYCLE = 256;
  localparam logic [23:0] BYTES_PER_CYCLE = 24'(BUS_BITS_PER_CYCLE / 8);
  localparam logic [23:0] IPG_BYTES = 24'h00000C;
  localparam logic [23:0] PREAMBLE_BYTES = 24'h000008;
  localparam logic signed [23:0] CREDIT_CAP = 24'sh00FFFF;
  // CRC constants, bit-reflected forms.
  localparam logic [31:0] ETH_POLY = 32'hEDB88320;
  localparam logic [31:0] CASTAG_POLY = 32'h82F63B78;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] ETH_RESIDUE = 32'hDEBB20E3;
  localparam logic [31:0] CASTAG_RESIDUE = 32'hB798B438;
  localparam logic [31:0] CRC_MARK = 32'h000000FF;
  // Lane numbering of the CRC engines.
  localparam int LANE_HOST_IN = 0;
  localparam int LANE_HOST_OUT = 1;
  localparam int LANE_RX_FIRST = 2;
  localparam int LANE_TX_FIRST = 4;
  // AHB-Lite codes.
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;

  typedef struct packed {
    logic valid;
    logic last;
    logic fcs;
    logic [7:0] data;
    logic crc_type;
    logic crc_present;
  } srcfc_lane_in_t;

  typedef struct packed {
    logic done;
    logic ok;
    logic append;
    logic [31:0] crc;
  } srcfc_lane_out_t;

  typedef struct packed {
    logic valid;
    logic [2:0] pri;
    logic [15:0] len;
  } srcfc_frame_start_t;

  typedef enum logic [1:0] {
    FC_IDLE = 2'b01,
    FC_RETRY = 2'b10
  } srcfc_fc_state_t;
endpackage : srcfc_pkg

// ### rtl/srcfc_top.sv
// Traffic control of the three-port switch: rate shaping, frame check sequence lanes and receive flow control.
// Overview of operation
// - Host ingress priorities each get their own shaper when their enable bit is set.
// - Host bulk priorities send only if both port FIFOs keep their minimum free blocks.
// - Allowed rate is idle over idle plus send, times clock MHz, times 256.
// - Inter-packet gap and preamble bytes are charged to the shaper with each frame.
// - Each Ethernet port shapes egress per priority under its own enable bits.
// - Ethernet bulk priorities send only while no limited priority has both a request and credit.
// - Host frames are never dropped; Ethernet bulk frames may be dropped.
// - Ethernet receive checks every frame's CRC with the MAC's chosen polynomial.
// - Egress frames get a freshly generated CRC of the configured type after checking.
// - A frame that arrived with a bad CRC leaves a MAC port with one CRC byte inverted.
// - Host ingress does not check CRC; the check happens at MAC egress.
// - Host ingress appends a CRC unless the frame info says one is present.
// - Host gives the CRC type per frame and the device follows it each frame.
// - Host egress always flags CRC present, typed by the switch control bit.
// - A full Ethernet destination, or host buffer at threshold words, triggers flow control.
// - Frames go to destinations with room and retry the others until accepted.
// - Trigger holds until the frame is sent and the receive packet count is zero.
// - Ethernet receive flow control is off after reset until software enables it.
// - Host receive flow control is on by default and works by dropping stream ready.
`timescale 1ns/1ps
`default_nettype none
module srcfc_top #(
  parameter int BLOCK_W = 8,
  parameter int PKT_CNT_W = 8,
  parameter int WORD_CNT_W = 16
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // AHB-Lite register slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Host ingress arbitration
  input wire logic [7:0] HOST_RX_REQ,
  output logic [7:0] HOST_RX_PERMIT,
  input wire srcfc_pkg::srcfc_frame_start_t HOST_RX_START,
  input wire logic [BLOCK_W-1:0] P1_TX_FREE_BLOCKS,
  input wire logic [BLOCK_W-1:0] P2_TX_FREE_BLOCKS,
  // Ethernet egress arbitration, index 0 is port 1
  input wire logic [1:0][7:0] PORT_TX_REQ,
  output logic [1:0][7:0] PORT_TX_PERMIT,
  input wire srcfc_pkg::srcfc_frame_start_t [1:0] PORT_TX_START,
  // CRC lanes
  input wire srcfc_pkg::srcfc_lane_in_t [5:0] LANE_IN,
  output logic [5:0] LANE_DONE,
  output srcfc_pkg::srcfc_lane_out_t [5:0] LANE_OUT,
  // Ethernet receive flow control
  input wire logic [1:0] RX_FRAME_VALID,
  input wire logic [1:0][2:0] RX_FRAME_DEST,
  output logic [1:0] RX_FRAME_READY,
  output logic [1:0][2:0] RX_DELIVER,
  input wire logic [1:0][PKT_CNT_W-1:0] RX_PKT_COUNT,
  input wire logic P1_DEST_FULL,
  input wire logic P2_DEST_FULL,
  input wire logic [WORD_CNT_W-1:0] HOST_TX_WORDS,
  output logic [1:0] FLOW_TRIGGER,
  // Host receive pushback
  input wire logic HOST_RX_FIFO_FULL,
  output logic STREAM_RECEIVE_READY
);
  if (BLOCK_W < 1 || BLOCK_W > 8) begin : g_bad_block
    $error("BLOCK_W must lie between 1 and 8.");
  end
  if (WORD_CNT_W < 1 || WORD_CNT_W > 16) begin : g_bad_words
    $error("WORD_CNT_W must lie between 1 and 16.");
  end
  if (PKT_CNT_W < 1) begin : g_bad_pkt
    $error("PKT_CNT_W must be at least 1.");
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SRST);

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d, input logic castag);
    logic [31:0] r;
    logic [31:0] poly;
    r = c ^ {24'h000000, d};
    poly = castag ? srcfc_pkg::CASTAG_POLY : srcfc_pkg::ETH_POLY;
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ poly) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  // Register file.
  logic host_crc_sel;
  logic host_flow_en;
  logic [31:0] host_pri;
  logic [15:0] port_pri;
  logic [1:0] mac_crc;
  logic [1:0] mac_flow_en;
  logic [15:0] thresh;
  logic [31:0] host_shape [8];
  logic [31:0] port_shape [8];
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [23:0] shp_ok;
  logic [1:0] retry_busy;

  wire addr_phase = HSEL && HREADY && (HTRANS == srcfc_pkg::HTRANS_NONSEQ);
  wire [2:0] wr_page = wr_addr[7:5];
  wire [2:0] wr_idx = wr_addr[4:2];

  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h00000000;
    case (a)
      srcfc_pkg::ADDR_SWITCH_CTRL: begin
        w[srcfc_pkg::CTRL_HOST_CRC_BIT] = host_crc_sel;
        w[srcfc_pkg::CTRL_HOST_FLOW_BIT] = host_flow_en;
      end
      srcfc_pkg::ADDR_HOST_PRI: w = {8'h00, host_pri[23:0]};
      srcfc_pkg::ADDR_PORT_PRI: w = {16'h0000, port_pri};
      srcfc_pkg::ADDR_MAC_CTRL: begin
        for (int p = 0; p < srcfc_pkg::NUM_ETH; p++) begin
          w[p*srcfc_pkg::MAC_PORT_STRIDE + srcfc_pkg::MAC_CRC_BIT] = mac_crc[p];
          w[p*srcfc_pkg::MAC_PORT_STRIDE + srcfc_pkg::MAC_FLOW_BIT] = mac_flow_en[p];
        end
      end
      srcfc_pkg::ADDR_THRESH: w = {16'h0000, thresh};
      srcfc_pkg::ADDR_STATUS: w = {4'h0, retry_busy, FLOW_TRIGGER, shp_ok};
      default: begin
        if (a[7:5] == srcfc_pkg::PAGE_HOST_SHAPE && a[1:0] == 2'h0) begin
          w = host_shape[a[4:2]];
        end else if (a[7:5] == srcfc_pkg::PAGE_PORT_SHAPE && a[1:0] == 2'h0) begin
          w = port_shape[a[4:2]];
        end
      end
    endcase
    return w;
  endfunction : read_word

  // Zero wait state slave; unmapped addresses read zero and ignore writes.
  assign HREADYOUT = 1'b1;
  assign HRESP = srcfc_pkg::HRESP_OKAY;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      HRDATA <= 32'h00000000;
    end else begin
      wr_pend <= addr_phase && HWRITE;
      wr_addr <= HADDR[7:0];
      if (addr_phase && !HWRITE) begin
        HRDATA <= read_word(HADDR[7:0]);
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      host_crc_sel <= 1'b0;
      host_flow_en <= srcfc_pkg::HOST_FLOW_RESET;
      host_pri <= 32'h00000000;
      port_pri <= 16'h0000;
      mac_crc <= 2'b00;
      mac_flow_en <= 2'b00;
      thresh <= srcfc_pkg::THRESH_RESET;
    end else if (wr_pend) begin
      case (wr_addr)
        srcfc_pkg::ADDR_SWITCH_CTRL: begin
          host_crc_sel <= HWDATA[srcfc_pkg::CTRL_HOST_CRC_BIT];
          host_flow_en <= HWDATA[srcfc_pkg::CTRL_HOST_FLOW_BIT];
        end
        srcfc_pkg::ADDR_HOST_PRI: host_pri <= {8'h00, HWDATA[23:0]};
        srcfc_pkg::ADDR_PORT_PRI: port_pri <= HWDATA[15:0];
        srcfc_pkg::ADDR_MAC_CTRL: begin
          mac_crc <= {HWDATA[srcfc_pkg::MAC_PORT_STRIDE + srcfc_pkg::MAC_CRC_BIT], HWDATA[srcfc_pkg::MAC_CRC_BIT]};
          mac_flow_en <= {HWDATA[srcfc_pkg::MAC_PORT_STRIDE + srcfc_pkg::MAC_FLOW_BIT],
                          HWDATA[srcfc_pkg::MAC_FLOW_BIT]};
        end
        srcfc_pkg::ADDR_THRESH: thresh <= HWDATA[15:0];
        default: ;
      endcase
    end
  end

  for (genvar i = 0; i < srcfc_pkg::NUM_PRI; i++) begin : g_shape_reg
    always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
        host_shape[i] <= 32'h00000000;
        port_shape[i] <= 32'h00000000;
      end else if (wr_pend && wr_idx == 3'(i) && wr_addr[1:0] == 2'h0) begin
        if (wr_page == srcfc_pkg::PAGE_HOST_SHAPE) begin
          host_shape[i] <= HWDATA;
        end
        if (wr_page == srcfc_pkg::PAGE_PORT_SHAPE) begin
          port_shape[i] <= HWDATA;
        end
      end
    end
  end

  // Shapers: set 0 is host ingress, sets 1 and 2 are egress of ports 1 and 2.
  wire [7:0] host_rlim = host_pri[7:0];
  wire [1:0][7:0] port_rlim = port_pri;
  wire [23:0] shp_en = {port_rlim, host_rlim};
  for (genvar s = 0; s < srcfc_pkg::NUM_SHAPERS; s++) begin : g_shp
    localparam int SET = s / srcfc_pkg::NUM_PRI;
    localparam int PRI = s % srcfc_pkg::NUM_PRI;
    logic open;
    logic [15:0] cnt;
    logic signed [23:0] credit;
    wire [31:0] counts = (SET == 0) ? host_shape[PRI] : port_shape[PRI];
    wire [15:0] send_cnt = counts[15:0];
    wire [15:0] idle_cnt = counts[srcfc_pkg::SHAPE_IDLE_LSB +: 16];
    wire srcfc_pkg::srcfc_frame_start_t st = (SET == 0) ? HOST_RX_START : PORT_TX_START[(SET == 0) ? 0 : SET - 1];
    wire charge = st.valid && st.pri == 3'(PRI);
    // The gap and preamble cost bus time too, so each frame pays for them.
    wire [23:0] cost = {8'h00, st.len} + srcfc_pkg::IPG_BYTES + srcfc_pkg::PREAMBLE_BYTES;
    wire signed [23:0] gained = open ? (credit + $signed(srcfc_pkg::BYTES_PER_CYCLE)) : credit;
    wire signed [23:0] capped = (gained > srcfc_pkg::CREDIT_CAP) ? srcfc_pkg::CREDIT_CAP : gained;
    wire signed [23:0] next_credit = charge ? (capped - $signed(cost)) : capped;
    // Open windows last the idle count, closed ones the send count, giving the idle share of 256 bits a clock.
    always_ff @(posedge CORE_CLK) begin
      if (SRST || !shp_en[s]) begin
        open <= 1'b0;
        cnt <= 16'h0000;
        credit <= 24'sh000000;
      end else begin
        credit <= next_credit;
        if (cnt == 16'h0000) begin
          open <= !open;
          cnt <= open ? send_cnt : idle_cnt;
        end else begin
          cnt <= cnt - 16'h0001;
        end
      end
    end
    assign shp_ok[s] = shp_en[s] && !credit[23] && credit != 24'sh000000;
  end

  // Host ingress: bulk priorities wait for free blocks instead of being dropped.
  wire [BLOCK_W-1:0] p1_min = host_pri[srcfc_pkg::P1_MIN_LSB +: BLOCK_W];
  wire [BLOCK_W-1:0] p2_min = host_pri[srcfc_pkg::P2_MIN_LSB +: BLOCK_W];
  wire blocks_ok = P1_TX_FREE_BLOCKS >= p1_min && P2_TX_FREE_BLOCKS >= p2_min;
  wire [7:0] host_rl_permit = HOST_RX_REQ & host_rlim & shp_ok[7:0];
  wire [7:0] host_bulk_permit = HOST_RX_REQ & ~host_rlim & {8{blocks_ok}};
  assign HOST_RX_PERMIT = host_rl_permit | host_bulk_permit;

  for (genvar p = 0; p < srcfc_pkg::NUM_ETH; p++) begin : g_egress
    wire [7:0] ok = shp_ok[(p + 1) * srcfc_pkg::NUM_PRI +: srcfc_pkg::NUM_PRI];
    wire [7:0] rl_live = PORT_TX_REQ[p] & port_rlim[p] & ok;
    wire [7:0] bulk = (rl_live == 8'h00) ? (PORT_TX_REQ[p] & ~port_rlim[p]) : 8'h00;
    assign PORT_TX_PERMIT[p] = rl_live | bulk;
  end

  // CRC lanes.
  for (genvar l = 0; l < srcfc_pkg::NUM_LANES; l++) begin : g_lane
    localparam bit IS_RX = (l == srcfc_pkg::LANE_RX_FIRST || l == srcfc_pkg::LANE_RX_FIRST + 1);
    localparam bit IS_TX = (l >= srcfc_pkg::LANE_TX_FIRST);
    localparam int PORT = IS_TX ? l - srcfc_pkg::LANE_TX_FIRST : (IS_RX ? l - srcfc_pkg::LANE_RX_FIRST : 0);
    logic in_frame;
    logic [31:0] chk;
    logic [31:0] gen;
    srcfc_pkg::srcfc_lane_out_t q;
    wire srcfc_pkg::srcfc_lane_in_t li = LANE_IN[l];
    wire chk_t = IS_RX ? mac_crc[PORT] : li.crc_type;
    wire gen_t = (l == srcfc_pkg::LANE_HOST_IN) ? li.crc_type :
                 (l == srcfc_pkg::LANE_HOST_OUT) ? host_crc_sel : mac_crc[PORT];
    wire [31:0] chk_base = in_frame ? chk : srcfc_pkg::CRC_INIT;
    wire [31:0] gen_base = in_frame ? gen : srcfc_pkg::CRC_INIT;
    wire [31:0] next_chk = crc_byte(chk_base, li.data, chk_t);
    wire [31:0] next_gen = li.fcs ? gen_base : crc_byte(gen_base, li.data, gen_t);
    wire good = next_chk == (chk_t ? srcfc_pkg::CASTAG_RESIDUE : srcfc_pkg::ETH_RESIDUE);
    wire [31:0] fin = ~next_gen;
    // Host ingress is never checked; a bad frame is caught later at MAC egress.
    wire lane_ok = (l == srcfc_pkg::LANE_HOST_IN || l == srcfc_pkg::LANE_HOST_OUT) ? 1'b1 : good;
    wire [31:0] crc_out = (IS_TX && !good) ? (fin ^ srcfc_pkg::CRC_MARK) : fin;
    wire append = (l == srcfc_pkg::LANE_HOST_IN) ? !li.crc_present :
                  (l == srcfc_pkg::LANE_HOST_OUT) ? 1'b1 : IS_TX;
    always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
        in_frame <= 1'b0;
        chk <= srcfc_pkg::CRC_INIT;
        gen <= srcfc_pkg::CRC_INIT;
        q <= '0;
      end else begin
        q.done <= li.valid && li.last;
        if (li.valid) begin
          chk <= next_chk;
          gen <= next_gen;
          in_frame <= !li.last;
          if (li.last) begin
            q.ok <= lane_ok;
            q.append <= append;
            q.crc <= crc_out;
          end
        end
      end
    end
    assign LANE_OUT[l] = q;
    assign LANE_DONE[l] = q.done;
  end

  // Ethernet receive flow control; destination bit 0 is host, 1 and 2 the Ethernet ports.
  wire host_dest_full = HOST_TX_WORDS >= thresh[WORD_CNT_W-1:0];
  wire [2:0] dest_full = {P2_DEST_FULL, P1_DEST_FULL, host_dest_full};
  for (genvar p = 0; p < srcfc_pkg::NUM_ETH; p++) begin : g_fc
    srcfc_pkg::srcfc_fc_state_t state;
    srcfc_pkg::srcfc_fc_state_t next_state;
    logic [2:0] pend;
    logic [2:0] next_pend;
    logic [2:0] next_deliver;
    logic trig;
    logic [2:0] deliver;
    wire take = RX_FRAME_VALID[p] && state == srcfc_pkg::FC_IDLE;
    // Without flow control the frame goes where there is room and the rest is dropped.
    always_comb begin
      next_pend = pend;
      next_deliver = 3'h0;
      unique case (state)
        srcfc_pkg::FC_IDLE: begin
          if (RX_FRAME_VALID[p]) begin
            next_deliver = RX_FRAME_DEST[p] & ~dest_full;
            next_pend = mac_flow_en[p] ? (RX_FRAME_DEST[p] & dest_full) : 3'h0;
          end
        end
        srcfc_pkg::FC_RETRY: begin
          next_deliver = pend & ~dest_full;
          next_pend = pend & dest_full;
        end
        default: begin
          next_pend = 3'h0;
        end
      endcase
      next_state = (next_pend != 3'h0) ? srcfc_pkg::FC_RETRY : srcfc_pkg::FC_IDLE;
    end
    // Held past delivery until the receive FIFO is empty, leaving room for runout.
    wire next_trig = mac_flow_en[p] && (next_pend != 3'h0 || (trig && RX_PKT_COUNT[p] != '0));
    always_ff @(posedge CORE_CLK) begin
      if (SRST) begin
        state <= srcfc_pkg::FC_IDLE;
        pend <= 3'h0;
        deliver <= 3'h0;
        trig <= 1'b0;
      end else begin
        state <= next_state;
        pend <= next_pend;
        deliver <= next_deliver;
        trig <= next_trig;
      end
    end
    assign RX_FRAME_READY[p] = state == srcfc_pkg::FC_IDLE;
    assign RX_DELIVER[p] = deliver;
    assign FLOW_TRIGGER[p] = trig;
    assign retry_busy[p] = state == srcfc_pkg::FC_RETRY;

    a_trigger_hold:
      assert property ($fell(trig) |-> $past(!mac_flow_en[p])
                       || ($past(next_pend) == 3'h0 && $past(RX_PKT_COUNT[p]) == '0))
        else $error("Flow trigger dropped while frame pending or FIFO not empty.");
    a_flow_off:
      assert property (!mac_flow_en[p] |=> !trig && state == srcfc_pkg::FC_IDLE)
        else $error("Flow control acted while disabled.");
    sequence s_blocked;
      take && mac_flow_en[p] && (RX_FRAME_DEST[p] & dest_full) != 3'h0;
    endsequence
    sequence s_retrying;
      trig && state == srcfc_pkg::FC_RETRY;
    endsequence
    a_retry_start:
      assert property (s_blocked |=> s_retrying)
        else $error("Blocked destination did not start retry with trigger.");
  end

  // A full host FIFO pushes back on the streaming interface.
  assign STREAM_RECEIVE_READY = !(host_flow_en && HOST_RX_FIFO_FULL);

  a_host_bulk_gate:
    assert property ((HOST_RX_PERMIT & ~host_rlim) != 8'h00 |-> P1_TX_FREE_BLOCKS >= p1_min && P2_TX_FREE_BLOCKS >= p2_min)
      else $error("Host bulk priority permitted without free blocks.");
  a_host_rlim_gate:
    assert property ((HOST_RX_PERMIT & host_rlim & ~shp_ok[7:0]) == 8'h00)
      else $error("Host limited priority permitted without shaper credit.");
  a_egress_bulk_hold:
    assert property ((PORT_TX_PERMIT[0] & ~port_rlim[0]) != 8'h00
                     |-> (PORT_TX_REQ[0] & port_rlim[0] & shp_ok[15:8]) == 8'h00)
      else $error("Egress bulk sent while a limited priority could send.");
  a_egress_rlim_gate:
    assert property ((PORT_TX_PERMIT[1] & port_rlim[1] & ~shp_ok[23:16]) == 8'h00)
      else $error("Egress limited priority permitted without shaper credit.");
  a_stream_push:
    assert property (host_flow_en && HOST_RX_FIFO_FULL |-> !STREAM_RECEIVE_READY)
      else $error("Stream ready not dropped on full host FIFO.");
  a_credit_charge:
    assert property (shp_en[0] && HOST_RX_START.valid && HOST_RX_START.pri == 3'h0 && !g_shp[0].open
                     && !SRST ##1 shp_en[0] |-> g_shp[0].credit == $past(g_shp[0].credit) - $signed($past(g_shp[0].cost)))
      else $error("Frame charge omits gap and preamble bytes.");
  a_window_load:
    assert property (shp_en[1] && g_shp[1].cnt == 16'h0000 && !g_shp[1].open ##1 shp_en[1]
                     |-> g_shp[1].open && g_shp[1].cnt == $past(g_shp[1].idle_cnt))
      else $error("Open window not loaded from idle count.");
  a_bad_crc_mark:
    assert property (LANE_IN[4].valid && LANE_IN[4].last && !g_lane[4].good
                     |=> LANE_OUT[4].done && !LANE_OUT[4].ok && LANE_OUT[4].crc[7:0] == ~$past(g_lane[4].fin[7:0]))
      else $error("Bad incoming CRC not marked on egress.");
  a_host_crc_append:
    assert property (LANE_IN[0].valid && LANE_IN[0].last |=> LANE_OUT[0].append == !$past(LANE_IN[0].crc_present))
      else $error("Host ingress CRC append does not follow frame info.");
  a_host_egress_flag:
    assert property (LANE_DONE[1] |-> LANE_OUT[1].append && LANE_OUT[1].ok)
      else $error("Host egress frame without CRC present flag.");
endmodule : srcfc_top
`default_nettype wire

// ### tb/srcfc_far_model.sv
// Far-side model: host transmit buffer level and MAC receive packet count.
`timescale 1ns/1ps
`default_nettype none
module srcfc_far_model (
  // Clock, reset, bench settings and levels seen by the switch.
  input wire logic clk,
  input wire logic srst,
  input wire logic [15:0] set_words,
  input wire logic [7:0] set_pkts,
  output logic [15:0] words,
  output logic [7:0] pkts
);
  always_ff @(posedge clk) {words, pkts} <= srst ? 24'h000000 : {set_words, set_pkts};
endmodule : srcfc_far_model
`default_nettype wire

// ### tb/srcfc_top_tb.sv
// Self-checking bench of the switch traffic control block.
`timescale 1ns/1ps
`default_nettype none
module srcfc_top_tb;
  logic clk = 1'b0, srst = 1'b1, hsel, hwrite, ffull, p1full, hready, hresp, sready;
  logic [1:0] htrans, valid, fcrdy, trig;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0] req, free, permit, spk, pkts;
  logic [15:0] sw, words;
  logic [5:0] done;
  logic [1:0][2:0] dest, dlv;
  srcfc_pkg::srcfc_lane_in_t [5:0] lin;
  srcfc_pkg::srcfc_lane_out_t [5:0] lout;
  int failures = 0, n_compared = 0;
  // The far side lags the bench by one edge, so every level change needs a cycle to land.
  srcfc_far_model far (.clk(clk), .srst(srst), .set_words(sw), .set_pkts(spk), .words(words), .pkts(pkts));
  srcfc_top uut (.CORE_CLK(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .HOST_RX_REQ(req), .HOST_RX_PERMIT(permit), .HOST_RX_START('0), .P1_TX_FREE_BLOCKS(free),
    .P2_TX_FREE_BLOCKS(free), .PORT_TX_REQ('0), .PORT_TX_PERMIT(), .PORT_TX_START('0), .LANE_IN(lin),
    .LANE_DONE(done), .LANE_OUT(lout), .RX_FRAME_VALID(valid), .RX_FRAME_DEST(dest), .RX_FRAME_READY(fcrdy),
    .RX_DELIVER(dlv), .RX_PKT_COUNT({2{pkts}}), .P1_DEST_FULL(p1full), .P2_DEST_FULL(1'b0),
    .HOST_TX_WORDS(words), .FLOW_TRIGGER(trig), .HOST_RX_FIFO_FULL(ffull), .STREAM_RECEIVE_READY(sready));
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_compared++;
    if (got !== exp) failures++;
    if (got !== exp) $display("mismatch %0t got %h exp %h", $time, got, exp);
  endtask : chk
  task automatic close_out;
    if (failures == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, 24'h000000, a, wr};
    do @(posedge clk); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic frame(input int l, input logic ty, input logic pr, input int nfcs);
    for (int i = 0; i <= nfcs; i++) begin
      lin[l] <= '{1'b1, i == nfcs, i > 0, 8'h00, ty, pr};
      @(posedge clk);
    end
    lin[l] <= '0;
  endtask : frame
  task automatic t_regs;
    bus(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'h0);
    chk(hresp, 1'b0);
    ffull <= 1'b1;
    #1 chk(sready, 1'b0);
  endtask : t_regs
  task automatic t_crc;
    frame(0, 1'b1, 1'b0, 0);
    #1 chk({lout[0].append, lout[0].crc}, {1'b1, 32'h527D5351});
    bus(1'b1, 8'h00, 32'h3);
    frame(1, 1'b0, 1'b0, 0);
    #1 chk({lout[1].append, lout[1].crc}, {1'b1, 32'h527D5351});
    frame(4, 1'b0, 1'b0, 4);
    #1 chk({done[4], lout[4].ok, lout[4].crc}, {2'h2, 32'hD202EF72});
  endtask : t_crc
  task automatic t_bulk;
    bus(1'b1, 8'h04, 32'h00040400);
    {req, free} <= {8'h01, 8'h03};
    #1 chk(permit, 8'h00);
    free <= 8'h04;
    #1 chk(permit, 8'h01);
  endtask : t_bulk
  task automatic t_shape;
    req <= 8'h80;
    bus(1'b1, 8'h5C, 32'h00030002);
    bus(1'b1, 8'h04, 32'h00040480);
    #1 chk(permit, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk(permit, 8'h80);
  endtask : t_shape
  task automatic t_flow;
    {p1full, valid, dest[0]} <= {1'b1, 2'h1, 3'h3};
    @(posedge clk);
    valid <= 2'h0;
    #1 chk({dlv[0], trig[0]}, 4'h2);
    {sw, spk, p1full} <= {16'h0100, 8'h01, 1'b0};
    bus(1'b1, 8'h0C, 32'h2);
    valid <= 2'h1;
    @(posedge clk);
    valid <= 2'h0;
    #1 chk({fcrdy[0], dlv[0], trig[0]}, 5'h05);
    sw <= 16'h0000;
    for (int i = 0; i < 9 && dlv[0] !== 3'h1; i++) #5;
    chk({trig[0], dlv[0]}, 4'h9);
    spk <= 8'h00;
    for (int i = 0; i < 9 && trig[0] !== 1'b0; i++) #5;
    chk({fcrdy[0], trig[0]}, 2'h2);
  endtask : t_flow
  initial begin
    #20000 failures++;
    close_out();
  end
  initial begin
    {hsel, hwrite, ffull, p1full, htrans, valid, haddr, hwdata, req, free, spk, sw, dest, lin} = '0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_crc();
    t_bulk();
    t_shape();
    t_flow();
    close_out();
  end
endmodule : srcfc_top_tb
`default_nettype wire
